/* File: core/cfsc_params.svh */
// Constants for the cooling fan speed controller
//
// Operation
// - Main fans are off, low or high; plate fan is on or off
// - Heatsink over threshold switches fans on
// - DC hold, brake, premag, adaptation start fans
// - Fans start shortly after power-up
// - Fans run at least ten minutes
// - Switch sensor 45 C starts low speed
// - Switch sensor 50 C raises to high
// - Switch sensor 40 C drops to low
// - Switch sensor 30 C drops to off
// - Ambient high at 35/45 C or below 10
// - Ambient high withdrawn at 30/40 C
// - Control board low at 55, off 45
// - Current over 60 percent demands low
// - Input plate fan always on when powered
// - Over-temperature switch sense is selectable
// - Switch change trips drive, alarm 29
// - Trip removes rectifier gating enable
// - Two relays follow selected status conditions
`ifndef CFSC_PARAMS_SVH
`define CFSC_PARAMS_SVH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define CFSC_OFS_CTRL      8'h00
`define CFSC_OFS_STATUS    8'h04
`define CFSC_OFS_TEMP      8'h08
`define CFSC_OFS_RELAY     8'h0c
`define CFSC_OFS_CLEAR     8'h10

// -----------------------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------------------
`define CFSC_CTRL_ESIZE    0
`define CFSC_CTRL_NOPEN    1
`define CFSC_CTRL_HSENA    2
`define CFSC_CTRL_HSLVL    15:8
`define CFSC_CTRL_RESET    32'h0000_3c04

// -----------------------------------------------------------------------------
// Temperature levels in degrees C, current percent and alarm code
// -----------------------------------------------------------------------------
`define CFSC_SW_ON_LOW     8'd45
`define CFSC_SW_TO_HIGH    8'd50
`define CFSC_SW_TO_LOW     8'd40
`define CFSC_SW_OFF        8'd30
`define CFSC_AMB_ON_D      8'd35
`define CFSC_AMB_ON_E      8'd45
`define CFSC_AMB_OFF_D     8'd30
`define CFSC_AMB_OFF_E     8'd40
`define CFSC_AMB_COLD      8'd10
`define CFSC_CB_ON         8'd55
`define CFSC_CB_OFF        8'd45
`define CFSC_CUR_PCT       60
`define CFSC_ALARM_OVT     8'd29

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define CFSC_CLK_HZ        100000000
`define CFSC_MIN_RUN_S     600
`define CFSC_START_MS      100
`define CFSC_MIN_RUN_CYC   (`CFSC_MIN_RUN_S * 64'd100000000)
`define CFSC_START_CYC     (`CFSC_START_MS * 64'd100000)

`endif

/* File: core/cfsc_pkg.sv */
// Types for the cooling fan speed controller
package cfsc_pkg;

	// Fan drive level, ordered so that a larger code is faster
	typedef enum logic [1:0]
	{
		CFSC_FAN_OFF  = 2'h0,
		CFSC_FAN_LOW  = 2'h1,
		CFSC_FAN_HIGH = 2'h2
	} cfsc_speed_t;

	// Drive operating states that force the fans on
	typedef struct packed
	{
		logic dc_hold;
		logic dc_brake;
		logic premag;
		logic auto_adapt;
	} cfsc_ops_t;

	// One sample of all temperatures and current
	typedef struct packed
	{
		logic [7:0]  t_switch;
		logic [7:0]  t_ambient;
		logic [7:0]  t_board;
		logic [15:0] i_out;
		logic [15:0] i_rated;
	} cfsc_sample_t;

endpackage

/* File: core/cfsc_fan_ctrl.sv */
// Cooling fan speed controller with AXI4-Lite registers
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "cfsc_params.svh"

module cfsc_fan_ctrl
#(
	parameter longint MIN_RUN_CYC = `CFSC_MIN_RUN_CYC,
	parameter longint START_CYC   = `CFSC_START_CYC,
	parameter int     N_STATUS    = 8
)
(
	// Clock and reset
	input  wire logic                  CLK,
	input  wire logic                  RST,
	// Sensor sample, valid for one cycle
	input  wire cfsc_pkg::cfsc_sample_t SAMPLE,
	input  wire logic                  SAMPLE_VALID,
	// Operating states and drive status
	input  wire cfsc_pkg::cfsc_ops_t   OPS,
	input  wire logic [N_STATUS-1:0]   STATUS_IN,
	// External over-temperature switch pin
	input  wire logic                  OVT_SWITCH,
	// Fan and protection outputs
	output cfsc_pkg::cfsc_speed_t      FAN_SPEED,
	output logic                       PLATE_FAN_ON,
	output logic                       TRIP,
	output logic [7:0]                 ALARM_CODE,
	output logic                       RECT_GATE_EN,
	output logic [1:0]                 RELAY,
	// AXI4-Lite slave
	input  wire logic [7:0]            S_AXI_AWADDR,
	input  wire logic                  S_AXI_AWVALID,
	output logic                       S_AXI_AWREADY,
	input  wire logic [31:0]           S_AXI_WDATA,
	input  wire logic [3:0]            S_AXI_WSTRB,
	input  wire logic                  S_AXI_WVALID,
	output logic                       S_AXI_WREADY,
	output logic [1:0]                 S_AXI_BRESP,
	output logic                       S_AXI_BVALID,
	input  wire logic                  S_AXI_BREADY,
	input  wire logic [7:0]            S_AXI_ARADDR,
	input  wire logic                  S_AXI_ARVALID,
	output logic                       S_AXI_ARREADY,
	output logic [31:0]                S_AXI_RDATA,
	output logic [1:0]                 S_AXI_RRESP,
	output logic                       S_AXI_RVALID,
	input  wire logic                  S_AXI_RREADY
);

	// Refuse parameter values that the relay slices and counters cannot serve
	if (N_STATUS < 1 || N_STATUS > 8)
	begin : g_bad_status
		$error("N_STATUS must be 1 to 8");
	end
	if (MIN_RUN_CYC < 1 || START_CYC < 1
		|| MIN_RUN_CYC > 64'hf_ffff_ffff || START_CYC > 64'hf_ffff_ffff)
	begin : g_bad_count
		$error("Counts must be 1 and fit in 36 bits");
	end

	// -------------------------------------------------------------------------
	// Register bus
	// -------------------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [15:0] relay_sel_reg;
	logic [7:0]  aw_addr_reg;
	logic        aw_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        w_have_reg;
	logic        clr_trip;
	logic        wr_go;
	logic [31:0] rd_data;
	logic [7:0]  last_sw_reg;
	logic [7:0]  last_amb_reg;
	logic [7:0]  last_cb_reg;

	assign wr_go = aw_have_reg && w_have_reg && !S_AXI_BVALID;

	// Address and data are taken in either order
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0;
			w_strb_reg    <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= 2'h0;
		end
		else
		begin
			S_AXI_AWREADY <= !aw_have_reg && !S_AXI_AWREADY && S_AXI_AWVALID;
			S_AXI_WREADY  <= !w_have_reg && !S_AXI_WREADY && S_AXI_WVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_have_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			if (wr_go)
			begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				if (aw_addr_reg == `CFSC_OFS_CTRL || aw_addr_reg == `CFSC_OFS_RELAY
					|| aw_addr_reg == `CFSC_OFS_CLEAR)
					S_AXI_BRESP <= 2'h0;
				else
					S_AXI_BRESP <= 2'h2;
			end
			else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// Writable registers, byte lanes honoured
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ctrl_reg      <= `CFSC_CTRL_RESET;
			relay_sel_reg <= 16'h0000;
		end
		else if (wr_go)
		begin
			if (aw_addr_reg == `CFSC_OFS_CTRL)
			begin
				if (w_strb_reg[0])
					ctrl_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1])
					ctrl_reg[15:8] <= w_data_reg[15:8];
			end
			else if (aw_addr_reg == `CFSC_OFS_RELAY)
			begin
				if (w_strb_reg[0])
					relay_sel_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1])
					relay_sel_reg[15:8] <= w_data_reg[15:8];
			end
		end
	end

	assign clr_trip = wr_go && aw_addr_reg == `CFSC_OFS_CLEAR && w_strb_reg[0] && w_data_reg[0];

	// Read data selection
	always_comb
	begin
		rd_data = 32'h0;
		if (S_AXI_ARADDR == `CFSC_OFS_CTRL)
			rd_data = {16'h0, ctrl_reg[15:8], 5'h0, ctrl_reg[2:0]};
		else if (S_AXI_ARADDR == `CFSC_OFS_STATUS)
			rd_data = {16'h0, ALARM_CODE, 2'h0, RELAY, RECT_GATE_EN, TRIP, FAN_SPEED};
		else if (S_AXI_ARADDR == `CFSC_OFS_TEMP)
			rd_data = {8'h0, last_cb_reg, last_amb_reg, last_sw_reg};
		else if (S_AXI_ARADDR == `CFSC_OFS_RELAY)
			rd_data = {16'h0, relay_sel_reg};
	end

	// Read channel, one read at a time
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0;
			S_AXI_RRESP   <= 2'h0;
		end
		else
		begin
			S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
			if (S_AXI_ARVALID && S_AXI_ARREADY)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rd_data;
				if (S_AXI_ARADDR == `CFSC_OFS_CTRL || S_AXI_ARADDR == `CFSC_OFS_STATUS
					|| S_AXI_ARADDR == `CFSC_OFS_TEMP || S_AXI_ARADDR == `CFSC_OFS_RELAY)
					S_AXI_RRESP <= 2'h0;
				else
					S_AXI_RRESP <= 2'h2;
			end
			else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	// -------------------------------------------------------------------------
	// Sensor demands, with hysteresis on the temperatures
	// -------------------------------------------------------------------------
	cfsc_pkg::cfsc_speed_t sw_dem_reg;
	logic                  amb_hi_reg;
	logic                  cb_lo_reg;
	logic                  cur_lo_reg;
	logic [7:0]            amb_on;
	logic [7:0]            amb_off;
	logic [23:0]           cur_x100;
	logic [23:0]           rated_x60;

	assign amb_on    = ctrl_reg[`CFSC_CTRL_ESIZE] ? `CFSC_AMB_ON_E : `CFSC_AMB_ON_D;
	assign amb_off   = ctrl_reg[`CFSC_CTRL_ESIZE] ? `CFSC_AMB_OFF_E : `CFSC_AMB_OFF_D;
	assign cur_x100  = 24'(SAMPLE.i_out) * 24'd100;
	assign rated_x60 = 24'(SAMPLE.i_rated) * 24'(`CFSC_CUR_PCT);

	// Demands update only on a new sample, hold between levels
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			sw_dem_reg   <= cfsc_pkg::CFSC_FAN_OFF;
			amb_hi_reg   <= 1'b0;
			cb_lo_reg    <= 1'b0;
			cur_lo_reg   <= 1'b0;
			last_sw_reg  <= 8'h00;
			last_amb_reg <= 8'h00;
			last_cb_reg  <= 8'h00;
		end
		else if (SAMPLE_VALID)
		begin
			last_sw_reg  <= SAMPLE.t_switch;
			last_amb_reg <= SAMPLE.t_ambient;
			last_cb_reg  <= SAMPLE.t_board;
			case (sw_dem_reg)
				cfsc_pkg::CFSC_FAN_OFF:
					if (SAMPLE.t_switch >= `CFSC_SW_ON_LOW)
						sw_dem_reg <= cfsc_pkg::CFSC_FAN_LOW;
				cfsc_pkg::CFSC_FAN_LOW:
					if (SAMPLE.t_switch >= `CFSC_SW_TO_HIGH)
						sw_dem_reg <= cfsc_pkg::CFSC_FAN_HIGH;
					else if (SAMPLE.t_switch <= `CFSC_SW_OFF)
						sw_dem_reg <= cfsc_pkg::CFSC_FAN_OFF;
				default:
					if (SAMPLE.t_switch <= `CFSC_SW_TO_LOW)
						sw_dem_reg <= cfsc_pkg::CFSC_FAN_LOW;
			endcase
			if (SAMPLE.t_ambient >= amb_on || SAMPLE.t_ambient < `CFSC_AMB_COLD)
				amb_hi_reg <= 1'b1;
			else if (SAMPLE.t_ambient <= amb_off)
				amb_hi_reg <= 1'b0;
			if (SAMPLE.t_board >= `CFSC_CB_ON)
				cb_lo_reg <= 1'b1;
			else if (SAMPLE.t_board <= `CFSC_CB_OFF)
				cb_lo_reg <= 1'b0;
			cur_lo_reg <= cur_x100 > rated_x60;
		end
	end

	// -------------------------------------------------------------------------
	// Combined demand, power-up start and minimum run
	// -------------------------------------------------------------------------
	logic                  ops_q1_reg;
	logic                  ops_q2_reg;
	logic                  hs_on;
	logic                  start_done_reg;
	logic [35:0]           start_cnt_reg;
	logic [35:0]           run_cnt_reg;
	cfsc_pkg::cfsc_speed_t dem_next;
	cfsc_pkg::cfsc_speed_t held_reg;

	// Operating states pass a two-stage synchroniser before use
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ops_q1_reg <= 1'b0;
			ops_q2_reg <= 1'b0;
		end
		else
		begin
			ops_q1_reg <= |OPS;
			ops_q2_reg <= ops_q1_reg;
		end
	end

	assign hs_on = ctrl_reg[`CFSC_CTRL_HSENA]
		&& last_sw_reg > ctrl_reg[`CFSC_CTRL_HSLVL];

	// Highest of all demands
	always_comb
	begin
		dem_next = sw_dem_reg;
		if (amb_hi_reg)
			dem_next = cfsc_pkg::CFSC_FAN_HIGH;
		else if (dem_next == cfsc_pkg::CFSC_FAN_OFF
			&& (cb_lo_reg || cur_lo_reg || ops_q2_reg || hs_on
			|| !start_done_reg))
			dem_next = cfsc_pkg::CFSC_FAN_LOW;
	end

	// Power-up start delay
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			start_cnt_reg  <= 36'h0;
			start_done_reg <= 1'b0;
		end
		else if (!start_done_reg && start_cnt_reg >= 36'(START_CYC - 1))
			start_done_reg <= 1'b1;
		else if (!start_done_reg)
			start_cnt_reg <= start_cnt_reg + 36'h1;
	end

	// Minimum run time once running, speed never below low
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			run_cnt_reg <= 36'h0;
			held_reg    <= cfsc_pkg::CFSC_FAN_OFF;
		end
		else if (dem_next != cfsc_pkg::CFSC_FAN_OFF)
		begin
			held_reg    <= dem_next;
			run_cnt_reg <= 36'(MIN_RUN_CYC);
		end
		else if (run_cnt_reg > 36'h1)
		begin
			run_cnt_reg <= run_cnt_reg - 36'h1;
			if (held_reg == cfsc_pkg::CFSC_FAN_HIGH)
				held_reg <= cfsc_pkg::CFSC_FAN_LOW;
		end
		else
		begin
			run_cnt_reg <= 36'h0;
			held_reg    <= cfsc_pkg::CFSC_FAN_OFF;
		end
	end

	// -------------------------------------------------------------------------
	// Over-temperature switch, relays and outputs
	// -------------------------------------------------------------------------
	logic ovt_s1_reg;
	logic ovt_s2_reg;
	logic ovt_act;

	// Two-stage synchroniser; resets to a closed contact, the idle level of the
	// default normally closed sense, so no false trip follows reset
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ovt_s1_reg <= 1'b1;
			ovt_s2_reg <= 1'b1;
		end
		else
		begin
			ovt_s1_reg <= OVT_SWITCH;
			ovt_s2_reg <= ovt_s1_reg;
		end
	end

	// Closed contact reads high; normally closed trips on open
	assign ovt_act = ctrl_reg[`CFSC_CTRL_NOPEN] ? ovt_s2_reg : !ovt_s2_reg;

	// Trip latch, new fault wins over clear
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			TRIP         <= 1'b0;
			ALARM_CODE   <= 8'h00;
			RECT_GATE_EN <= 1'b0;
		end
		else if (ovt_act)
		begin
			TRIP         <= 1'b1;
			ALARM_CODE   <= `CFSC_ALARM_OVT;
			RECT_GATE_EN <= 1'b0;
		end
		else if (clr_trip || !TRIP)
		begin
			TRIP         <= 1'b0;
			ALARM_CODE   <= 8'h00;
			RECT_GATE_EN <= 1'b1;
		end
	end

	// Each relay is the OR of its selected status bits
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_relay
			always_ff @(posedge CLK)
			begin
				if (RST)
					RELAY[gi] <= 1'b0;
				else
					RELAY[gi] <= |(STATUS_IN & relay_sel_reg[gi*8 +: N_STATUS]);
			end
		end
	endgenerate

	// Registered fan outputs
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			FAN_SPEED    <= cfsc_pkg::CFSC_FAN_OFF;
			PLATE_FAN_ON <= 1'b0;
		end
		else
		begin
			FAN_SPEED    <= held_reg;
			PLATE_FAN_ON <= 1'b1;
		end
	end

	// -------------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------------
	sequence s_sample_hot;
		SAMPLE_VALID && !amb_hi_reg && SAMPLE.t_ambient < amb_on
		&& SAMPLE.t_ambient >= `CFSC_AMB_COLD;
	endsequence

	a_speed_follows_held: assert property (@(posedge CLK) disable iff (RST)
		1'b1 |=> FAN_SPEED == $past(held_reg))
		else $error("Fan speed does not follow held speed");
	a_sw_low_on: assert property (@(posedge CLK) disable iff (RST)
		SAMPLE_VALID && sw_dem_reg == cfsc_pkg::CFSC_FAN_OFF && SAMPLE.t_switch >= 8'd45
		|=> sw_dem_reg == cfsc_pkg::CFSC_FAN_LOW)
		else $error("Switch sensor did not demand low at 45");
	a_sw_to_high: assert property (@(posedge CLK) disable iff (RST)
		SAMPLE_VALID && sw_dem_reg == cfsc_pkg::CFSC_FAN_LOW && SAMPLE.t_switch >= 8'd50
		|=> sw_dem_reg == cfsc_pkg::CFSC_FAN_HIGH ##2 FAN_SPEED == cfsc_pkg::CFSC_FAN_HIGH)
		else $error("Fans not raised to high at 50");
	a_sw_to_low: assert property (@(posedge CLK) disable iff (RST)
		SAMPLE_VALID && sw_dem_reg == cfsc_pkg::CFSC_FAN_HIGH && SAMPLE.t_switch <= 8'd40
		|=> sw_dem_reg == cfsc_pkg::CFSC_FAN_LOW)
		else $error("Switch sensor did not drop to low at 40");
	a_sw_off: assert property (@(posedge CLK) disable iff (RST)
		SAMPLE_VALID && sw_dem_reg == cfsc_pkg::CFSC_FAN_LOW && SAMPLE.t_switch <= 8'd30
		|=> sw_dem_reg == cfsc_pkg::CFSC_FAN_OFF)
		else $error("Switch sensor did not drop to off at 30");
	a_amb_cold_high: assert property (@(posedge CLK) disable iff (RST)
		SAMPLE_VALID && SAMPLE.t_ambient < 8'd10 |=> ##2 FAN_SPEED == cfsc_pkg::CFSC_FAN_HIGH)
		else $error("Cold ambient did not give high speed");
	a_amb_hold: assert property (@(posedge CLK) disable iff (RST)
		s_sample_hot ##0 SAMPLE.t_ambient > amb_off |=> !amb_hi_reg)
		else $error("Ambient demand changed inside band");
	a_trip_gate: assert property (@(posedge CLK) disable iff (RST)
		ovt_act |=> TRIP && !RECT_GATE_EN && ALARM_CODE == 8'd29)
		else $error("Trip did not remove rectifier gating");
	a_plate_on: assert property (@(posedge CLK) disable iff (RST)
		!$past(RST) |-> PLATE_FAN_ON)
		else $error("Input plate fan not on");
	a_min_run: assert property (@(posedge CLK) disable iff (RST)
		dem_next != cfsc_pkg::CFSC_FAN_OFF |=> ##1 (FAN_SPEED != cfsc_pkg::CFSC_FAN_OFF) [*8])
		else $error("Fans stopped inside minimum run");

endmodule

/* File: verification/cfsc_sensor_model.sv */
// Sensor front end model that hands temperature and current samples to the fan controller
`timescale 1ns/100ps

module cfsc_sensor_model
(
	// Clock
	input  wire logic              clk,
	// Sample towards the controller
	output cfsc_pkg::cfsc_sample_t sample,
	output logic                   sample_valid
);

	// Bus starts idle with no sample offered
	initial
	begin
		sample = '0;
		sample_valid = 1'b0;
	end

	// Offer one sample for one cycle, then scramble the idle bus
	task automatic send(input logic [7:0] sw, input logic [7:0] amb, input logic [7:0] brd,
		input logic [15:0] io, input logic [15:0] ir);
		@(posedge clk);
		sample <= {sw, amb, brd, io, ir};
		sample_valid <= 1'b1;
		@(posedge clk);
		sample <= ~{sw, amb, brd, io, ir}; // Stale value must not be relied on
		sample_valid <= 1'b0;
	endtask

endmodule

/* File: verification/tb_cooling_fan_speed_controller.sv */
// Self-checking testbench for the cooling fan speed controller
`timescale 1ns/100ps

module tb_cooling_fan_speed_controller;

	// Short counts so the run stays brief
	localparam longint MIN_RUN = 50;
	localparam cfsc_pkg::cfsc_speed_t OFF = cfsc_pkg::CFSC_FAN_OFF;
	localparam cfsc_pkg::cfsc_speed_t LO  = cfsc_pkg::CFSC_FAN_LOW;
	localparam cfsc_pkg::cfsc_speed_t HI  = cfsc_pkg::CFSC_FAN_HIGH;

	// Stimulus and observed signals
	logic                   clk, rst, sample_valid, ovt_pin;
	cfsc_pkg::cfsc_sample_t sample;
	cfsc_pkg::cfsc_ops_t    ops;
	logic [7:0]             status_in, alarm, awaddr, araddr;
	cfsc_pkg::cfsc_speed_t  fan_speed;
	logic                   plate_on, trip, rect_en;
	logic [1:0]             relay, bresp, rresp;
	logic                   awvalid, wvalid, bready, arvalid, rready;
	logic                   awready, wready, bvalid, arready, rvalid;
	logic [31:0]            wdata, rdata, rd;
	int                     err_count = 0;
	int                     n_checks = 0;
	int                     cyc = 0;

	cfsc_fan_ctrl #(.MIN_RUN_CYC(MIN_RUN), .START_CYC(10), .N_STATUS(8)) uut
	(
		.CLK(clk), .RST(rst), .SAMPLE(sample), .SAMPLE_VALID(sample_valid), .OPS(ops),
		.STATUS_IN(status_in), .OVT_SWITCH(ovt_pin), .FAN_SPEED(fan_speed),
		.PLATE_FAN_ON(plate_on), .TRIP(trip), .ALARM_CODE(alarm), .RECT_GATE_EN(rect_en),
		.RELAY(relay), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
	);

	cfsc_sensor_model sm (.clk(clk), .sample(sample), .sample_valid(sample_valid));

	// Clock generator
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Cuts a hang short
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			err_count++;
			close_out();
		end
	end

	// -------------------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------------------
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_spd(input cfsc_pkg::cfsc_speed_t exp);
		n_checks++;
		if (fan_speed !== exp)
		begin
			err_count++;
			$display("Error at %0t: speed %h expected %h", $time, fan_speed, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		chk({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rd = rdata;
		chk({30'h0, rresp}, {30'h0, er});
		rready <= 1'b0;
	endtask

	// Sample with 100 A rating, let the demand reach the fans, compare
	task automatic step(input logic [7:0] sw, input logic [7:0] amb, input logic [7:0] brd,
		input logic [15:0] io, input cfsc_pkg::cfsc_speed_t e);
		sm.send(sw, amb, brd, io, 16'h0064);
		tick(5);
		chk_spd(e);
	endtask

	// Wait out the minimum run and expect the fans stopped
	task automatic run_out();
		tick(MIN_RUN + 20);
		chk_spd(OFF);
	endtask

	// -------------------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------------------
	task automatic t_powerup();
		int n;
		n = 0;
		tick(3);
		chk_spd(LO);
		chk({31'h0, plate_on}, 32'h1);
		chk({31'h0, rect_en}, 32'h1);
		while (fan_speed === LO && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, n >= MIN_RUN}, 32'h1);
		chk_spd(OFF);
		$display("Power-up start done");
	endtask

	task automatic t_regs();
		axi_rd(8'h00, 2'h0);
		chk(rd, 32'h0000_3c04);
		axi_rd(8'h20, 2'h2);
		chk(rd, 32'h0);
		axi_wr(8'h20, 32'h1, 2'h2);
		$display("Register map done");
	endtask

	// Switch sensor walk: 44 45 49 50 41 40 31 then 30
	task automatic t_switch();
		step(8'h2c, 8'h14, 8'h19, 16'h0, OFF);
		step(8'h2d, 8'h14, 8'h19, 16'h0, LO);
		step(8'h31, 8'h14, 8'h19, 16'h0, LO);
		step(8'h32, 8'h14, 8'h19, 16'h0, HI);
		step(8'h29, 8'h14, 8'h19, 16'h0, HI);
		step(8'h28, 8'h14, 8'h19, 16'h0, LO);
		step(8'h1f, 8'h14, 8'h19, 16'h0, LO);
		tick(MIN_RUN + 20);
		chk_spd(LO);
		step(8'h1e, 8'h14, 8'h19, 16'h0, LO);
		run_out();
		axi_rd(8'h08, 2'h0);
		chk(rd & 32'h00ff_ffff, 32'h0019_141e);
		$display("Switch sensor done");
	endtask

	// Ambient walk for both sizes, plus the cold case
	task automatic t_ambient();
		step(8'h19, 8'h22, 8'h19, 16'h0, OFF);
		step(8'h19, 8'h23, 8'h19, 16'h0, HI);
		step(8'h19, 8'h1f, 8'h19, 16'h0, HI);
		step(8'h19, 8'h1e, 8'h19, 16'h0, LO);
		run_out();
		step(8'h19, 8'h09, 8'h19, 16'h0, HI);
		step(8'h19, 8'h14, 8'h19, 16'h0, LO);
		run_out();
		axi_wr(8'h00, 32'h0000_3c05, 2'h0);
		step(8'h19, 8'h2c, 8'h19, 16'h0, OFF);
		step(8'h19, 8'h2d, 8'h19, 16'h0, HI);
		step(8'h19, 8'h29, 8'h19, 16'h0, HI);
		step(8'h19, 8'h28, 8'h19, 16'h0, LO);
		run_out();
		axi_wr(8'h00, 32'h0000_3c04, 2'h0);
		$display("Ambient sensor done");
	endtask

	// Control board 54 55 46 then 45, and current 60 then 61 percent
	task automatic t_board_current();
		step(8'h19, 8'h14, 8'h36, 16'h0, OFF);
		step(8'h19, 8'h14, 8'h37, 16'h0, LO);
		step(8'h19, 8'h14, 8'h2e, 16'h0, LO);
		tick(MIN_RUN + 20);
		chk_spd(LO);
		step(8'h19, 8'h14, 8'h2d, 16'h0, LO);
		run_out();
		step(8'h19, 8'h14, 8'h19, 16'h003c, OFF);
		step(8'h19, 8'h14, 8'h19, 16'h003d, LO);
		step(8'h19, 8'h14, 8'h19, 16'h0, LO);
		run_out();
		$display("Board and current done");
	endtask

	// Each operating state, then the heatsink threshold lowered to 32
	task automatic t_ops_heatsink();
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			ops <= cfsc_pkg::cfsc_ops_t'(4'h8 >> i);
			tick(6);
			chk({31'h0, fan_speed != OFF}, 32'h1);
			@(posedge clk);
			ops <= '0;
			run_out();
		end
		axi_wr(8'h00, 32'h0000_2004, 2'h0);
		step(8'h20, 8'h14, 8'h19, 16'h0, OFF);
		sm.send(8'h23, 8'h14, 8'h19, 16'h0, 16'h0064);
		tick(5);
		chk({31'h0, fan_speed != OFF}, 32'h1);
		axi_wr(8'h00, 32'h0000_3c04, 2'h0);
		step(8'h19, 8'h14, 8'h19, 16'h0, LO);
		run_out();
		$display("Operating states and heatsink done");
	endtask

	task automatic set_pin(input logic v);
		@(posedge clk);
		ovt_pin <= v;
		tick(5);
	endtask

	// Normally closed opens, then normally open closes, with clears
	task automatic t_overtemp();
		set_pin(1'b0);
		chk({31'h0, trip}, 32'h1);
		chk({24'h0, alarm}, 32'h1d);
		chk({31'h0, rect_en}, 32'h0);
		axi_rd(8'h04, 2'h0);
		chk(rd & 32'hff0c, 32'h1d04);
		set_pin(1'b1);
		axi_wr(8'h10, 32'h1, 2'h0);
		tick(3);
		chk({30'h0, trip, rect_en}, 32'h1);
		chk({24'h0, alarm}, 32'h0);
		axi_wr(8'h00, 32'h0000_3c06, 2'h0);
		tick(5);
		chk({31'h0, trip}, 32'h1);
		axi_wr(8'h10, 32'h1, 2'h0);
		tick(3);
		chk({31'h0, trip}, 32'h1);
		set_pin(1'b0);
		axi_wr(8'h10, 32'h1, 2'h0);
		tick(3);
		chk({31'h0, trip}, 32'h0);
		$display("Over-temperature done");
	endtask

	task automatic set_status(input logic [7:0] v, input logic [1:0] e);
		@(posedge clk);
		status_in <= v;
		tick(3);
		chk({30'h0, relay}, {30'h0, e});
	endtask

	task automatic t_relay();
		axi_wr(8'h0c, 32'h0000_8001, 2'h0);
		set_status(8'h01, 2'h1);
		set_status(8'h80, 2'h2);
		set_status(8'h7e, 2'h0);
		axi_wr(8'h0c, 32'h0000_0302, 2'h0);
		set_status(8'h02, 2'h3);
		axi_rd(8'h0c, 2'h0);
		chk(rd & 32'hffff, 32'h0302);
		$display("Relays done");
	endtask

	// Main sequence
	initial
	begin
		rst = 1'b1;
		ops = '0;
		status_in = 8'h00;
		ovt_pin = 1'b1;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		tick(2);
		rst <= 1'b0;
		t_powerup();
		t_regs();
		t_switch();
		t_ambient();
		t_board_current();
		t_ops_heatsink();
		t_overtemp();
		t_relay();
		close_out();
	end

endmodule
